// *** core/dmb_pkg.sv ***
package dmb_pkg;

  // Register map, byte addresses on the control bus
  localparam int          ADDR_W      = 8;
  localparam logic [7:0]  MODE1_ADDR  = 8'h00;
  localparam logic [7:0]  MODE5_ADDR  = 8'h04;
  localparam logic [7:0]  STATUS_ADDR = 8'h08;
  localparam logic [7:0]  COUNT_ADDR  = 8'h0C;

  // Mode bit positions inside the data word
  localparam int TERM_STROBE_BIT = 11;
  localparam int MASK_BIT        = 10;
  localparam int WR_INV_BIT      = 11;
  localparam int RD_INV_BIT      = 12;
  localparam int MODE_STRB_LANE  = 1;

  // Reset values of the mode bits: everything off
  localparam logic       TERM_RST  = 1'b0;
  localparam logic [2:0] MODE5_RST = 3'h0;

  // Status word bit positions
  localparam int ST_MASK_BIT     = 0;
  localparam int ST_WR_INV_BIT   = 1;
  localparam int ST_RD_INV_BIT   = 2;
  localparam int ST_TERM_BIT     = 3;
  localparam int ST_RX_EN_BIT    = 4;
  localparam int ST_CONFLICT_BIT = 5;
  localparam int ST_HAS_MI_BIT   = 6;
  localparam int ST_HAS_TD_BIT   = 7;

  // Burst framing and the inversion threshold
  localparam int         BURST_LEN  = 8;
  localparam int         BEAT_W     = 3;
  localparam logic [3:0] ZERO_LIMIT = 4'h4;

  // Bus responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_DECERR = 2'h3;

  // Number of zero bits in a byte
  function automatic logic [3:0] dmb_zeros(input logic [7:0] b);
    logic [3:0] n;
    n = 4'h0;
    for (int i = 0; i < 8; i++)
    begin
      n = n + {3'h0, ~b[i]};
    end
    return n;
  endfunction

endpackage

// *** core/dmb_lane.sv ***
`timescale 1ns/1ps
// One byte lane of the shared side-band pin: write decode and read encode
module dmb_lane
  import dmb_pkg::*;
#(
  parameter int W = 8
)
(
  input  wire logic [W-1:0] wr_byte_i,
  input  wire logic         pin_i,
  input  wire logic         mask_en_i,
  input  wire logic         wr_inv_en_i,
  input  wire logic [W-1:0] rd_byte_i,
  input  wire logic         rd_inv_en_i,
  output logic      [W-1:0] wr_byte_o,
  output logic              wr_keep_o,
  output logic      [W-1:0] rd_byte_o,
  output logic              rd_flag_o
);

  logic [7:0] rd_wide;
  logic       heavy;

  // Narrow lanes pad with ones so the padding never counts as zeros
  always_comb
  begin
    rd_wide         = 8'hFF;
    rd_wide[W-1:0]  = rd_byte_i;
  end

  assign heavy = dmb_zeros(rd_wide) > ZERO_LIMIT;

  // Write side: pin low masks or inverts, pin high passes
  always_comb
  begin
    wr_keep_o = !(mask_en_i && !pin_i);
    wr_byte_o = (wr_inv_en_i && !pin_i) ? ~wr_byte_i : wr_byte_i;
  end

  // Read side: invert heavy bytes and flag them low
  always_comb
  begin
    rd_flag_o = !(rd_inv_en_i && heavy);
    rd_byte_o = rd_flag_o ? rd_byte_i : ~rd_byte_i;
  end

endmodule

// *** core/dmb_sideband.sv ***
`timescale 1ns/1ps
module dmb_sideband
  import dmb_pkg::*;
#(
  parameter int DQ_W = 8
)
(
  input  wire logic                  clk_sys_i,
  input  wire logic                  rst_i,
  input  wire logic                  s_axi_awvalid_i,
  output logic                       s_axi_awready_o,
  input  wire logic [ADDR_W-1:0]     s_axi_awaddr_i,
  input  wire logic                  s_axi_wvalid_i,
  output logic                       s_axi_wready_o,
  input  wire logic [31:0]           s_axi_wdata_i,
  input  wire logic [3:0]            s_axi_wstrb_i,
  output logic                       s_axi_bvalid_o,
  input  wire logic                  s_axi_bready_i,
  output logic      [1:0]            s_axi_bresp_o,
  input  wire logic                  s_axi_arvalid_i,
  output logic                       s_axi_arready_o,
  input  wire logic [ADDR_W-1:0]     s_axi_araddr_i,
  output logic                       s_axi_rvalid_o,
  input  wire logic                  s_axi_rready_i,
  output logic      [31:0]           s_axi_rdata_o,
  output logic      [1:0]            s_axi_rresp_o,
  input  wire logic                  wr_valid_i,
  input  wire logic [DQ_W-1:0]       dq_i,
  input  wire logic [(DQ_W+7)/8-1:0] bus_inv_flag_i,
  input  wire logic                  rd_valid_i,
  input  wire logic [DQ_W-1:0]       rd_data_i,
  input  wire logic [2:0]            dqs_rtt_i,
  output logic                       arr_we_o,
  output logic      [DQ_W-1:0]       arr_data_o,
  output logic      [(DQ_W+7)/8-1:0] arr_keep_o,
  output logic      [BEAT_W-1:0]     arr_beat_o,
  output logic      [DQ_W-1:0]       dq_o,
  output logic                       dq_oe_o,
  output logic      [(DQ_W+7)/8-1:0] bus_inv_flag_o,
  output logic      [(DQ_W+7)/8-1:0] bus_inv_flag_oe_o,
  output logic      [BEAT_W-1:0]     rd_beat_o,
  output logic                       rx_en_o,
  output logic      [2:0]            term_rtt_o
);

  localparam int   LANES  = (DQ_W + 7) / 8;
  localparam int   LANE_W = DQ_W / LANES;
  localparam logic HAS_MI = (DQ_W >= 8);
  localparam logic HAS_TD = (DQ_W == 8);

  typedef struct packed {
    logic                awready;
    logic                wready;
    logic                aw_got;
    logic                w_got;
    logic [ADDR_W-1:0]   aw_addr;
    logic [31:0]         w_data;
    logic [3:0]          w_strb;
    logic                bvalid;
    logic [1:0]          bresp;
    logic                arready;
    logic                rvalid;
    logic [31:0]         rdata;
    logic [1:0]          rresp;
    logic                term_en;
    logic [2:0]          mode5;
    logic [BEAT_W-1:0]   wr_beat;
    logic [BEAT_W-1:0]   rd_beat;
    logic                arr_we;
    logic [DQ_W-1:0]     arr_data;
    logic [LANES-1:0]    arr_keep;
    logic [BEAT_W-1:0]   arr_beat;
    logic [DQ_W-1:0]     dq_out;
    logic                dq_oe;
    logic [LANES-1:0]    flag_out;
    logic [LANES-1:0]    flag_oe;
    logic [BEAT_W-1:0]   rd_beat_out;
    logic                rx_en;
    logic [2:0]          term_rtt;
    logic [15:0]         masked_cnt;
  } dmb_state_t;

  dmb_state_t st_r;
  dmb_state_t st_nxt;

  logic             eff_mask;
  logic             eff_wr_inv;
  logic             eff_rd_inv;
  logic             eff_term;
  logic             conflict;
  logic [DQ_W-1:0]  lw_data;
  logic [LANES-1:0] lw_keep;
  logic [DQ_W-1:0]  lr_data;
  logic [LANES-1:0] lr_flag;
  logic [LANES-1:0] pin_seen;

  ////////////////////////////////////////////////////////////////////////////
  // Effective modes; a part without a function never turns it on
  assign eff_term   = HAS_TD && st_r.term_en;
  assign eff_mask   = HAS_MI && !eff_term && st_r.mode5[0];
  // Mask wins if software sets both, so one write function is ever live
  assign eff_wr_inv = HAS_MI && !eff_term && st_r.mode5[1] && !st_r.mode5[0];
  assign eff_rd_inv = HAS_MI && !eff_term && st_r.mode5[2];
  assign conflict   = st_r.mode5[0] && st_r.mode5[1];
  // Receiver off reads as a constant high, so the pin cannot act
  assign pin_seen   = bus_inv_flag_i | {LANES{!st_r.rx_en}};

  ////////////////////////////////////////////////////////////////////////////
  // Per-lane codecs, one per byte of the data bus
  for (genvar g = 0; g < LANES; g++)
  begin : g_lane
    dmb_lane #(
      .W (LANE_W)
    ) u_lane (
      .wr_byte_i   (dq_i[g*LANE_W +: LANE_W]),
      .pin_i       (pin_seen[g]),
      .mask_en_i   (eff_mask),
      .wr_inv_en_i (eff_wr_inv),
      .rd_byte_i   (rd_data_i[g*LANE_W +: LANE_W]),
      .rd_inv_en_i (eff_rd_inv),
      .wr_byte_o   (lw_data[g*LANE_W +: LANE_W]),
      .wr_keep_o   (lw_keep[g]),
      .rd_byte_o   (lr_data[g*LANE_W +: LANE_W]),
      .rd_flag_o   (lr_flag[g])
    );
  end

  ////////////////////////////////////////////////////////////////////////////
  // Next state: bus slave, mode bits, write and read beats
  always_comb
  begin
    st_nxt = st_r;
    // Write response handshake
    if (st_r.bvalid && s_axi_bready_i)
    begin
      st_nxt.bvalid = 1'b0;
    end
    if (s_axi_awvalid_i && st_r.awready)
    begin
      st_nxt.aw_got  = 1'b1;
      st_nxt.aw_addr = s_axi_awaddr_i;
    end
    if (s_axi_wvalid_i && st_r.wready)
    begin
      st_nxt.w_got  = 1'b1;
      st_nxt.w_data = s_axi_wdata_i;
      st_nxt.w_strb = s_axi_wstrb_i;
    end
    // Commit once both address and data are held
    if (st_r.aw_got && st_r.w_got && !st_r.bvalid)
    begin
      st_nxt.aw_got = 1'b0;
      st_nxt.w_got  = 1'b0;
      st_nxt.bvalid = 1'b1;
      st_nxt.bresp  = RESP_OKAY;
      if (st_r.aw_addr == MODE1_ADDR)
      begin
        if (st_r.w_strb[MODE_STRB_LANE])
        begin
          st_nxt.term_en = st_r.w_data[TERM_STROBE_BIT];
        end
      end
      else if (st_r.aw_addr == MODE5_ADDR)
      begin
        if (st_r.w_strb[MODE_STRB_LANE])
        begin
          st_nxt.mode5 = {st_r.w_data[RD_INV_BIT], st_r.w_data[WR_INV_BIT],
                          st_r.w_data[MASK_BIT]};
        end
      end
      else if (st_r.aw_addr != STATUS_ADDR && st_r.aw_addr != COUNT_ADDR)
      begin
        st_nxt.bresp = RESP_DECERR;
      end
    end
    // Ready only while the holding slot is empty and no response waits
    st_nxt.awready = !st_nxt.aw_got && !st_nxt.bvalid;
    st_nxt.wready  = !st_nxt.w_got && !st_nxt.bvalid;

    // Read channel: one outstanding read
    if (st_r.rvalid && s_axi_rready_i)
    begin
      st_nxt.rvalid = 1'b0;
    end
    if (s_axi_arvalid_i && st_r.arready)
    begin
      st_nxt.rvalid = 1'b1;
      st_nxt.rresp  = RESP_OKAY;
      st_nxt.rdata  = 32'h0000_0000;
      if (s_axi_araddr_i == MODE1_ADDR)
      begin
        st_nxt.rdata[TERM_STROBE_BIT] = st_r.term_en;
      end
      else if (s_axi_araddr_i == MODE5_ADDR)
      begin
        st_nxt.rdata[MASK_BIT]   = st_r.mode5[0];
        st_nxt.rdata[WR_INV_BIT] = st_r.mode5[1];
        st_nxt.rdata[RD_INV_BIT] = st_r.mode5[2];
      end
      else if (s_axi_araddr_i == STATUS_ADDR)
      begin
        st_nxt.rdata[ST_MASK_BIT]     = eff_mask;
        st_nxt.rdata[ST_WR_INV_BIT]   = eff_wr_inv;
        st_nxt.rdata[ST_RD_INV_BIT]   = eff_rd_inv;
        st_nxt.rdata[ST_TERM_BIT]     = eff_term;
        st_nxt.rdata[ST_RX_EN_BIT]    = st_r.rx_en;
        st_nxt.rdata[ST_CONFLICT_BIT] = conflict;
        st_nxt.rdata[ST_HAS_MI_BIT]   = HAS_MI;
        st_nxt.rdata[ST_HAS_TD_BIT]   = HAS_TD;
      end
      else if (s_axi_araddr_i == COUNT_ADDR)
      begin
        st_nxt.rdata[15:0] = st_r.masked_cnt;
      end
      else
      begin
        st_nxt.rresp = RESP_DECERR;
      end
    end
    st_nxt.arready = !st_nxt.rvalid;

    // Pin receiver follows the write functions, one cycle behind the mode
    st_nxt.rx_en    = eff_mask || eff_wr_inv;
    st_nxt.term_rtt = eff_term ? dqs_rtt_i : 3'h0;

    // Write beat: one lane byte and one pin bit per lane per transfer
    st_nxt.arr_we = wr_valid_i;
    if (wr_valid_i)
    begin
      st_nxt.arr_data = lw_data;
      st_nxt.arr_keep = lw_keep;
      st_nxt.arr_beat = st_r.wr_beat;
      st_nxt.wr_beat  = st_r.wr_beat + BEAT_W'(1);
      for (int i = 0; i < LANES; i++)
      begin
        st_nxt.masked_cnt = st_nxt.masked_cnt + {15'h0000, !lw_keep[i]};
      end
    end

    // Read beat: flag driven only while read inversion is live
    st_nxt.dq_oe   = rd_valid_i;
    st_nxt.flag_oe = {LANES{rd_valid_i && eff_rd_inv}};
    if (rd_valid_i)
    begin
      st_nxt.dq_out      = lr_data;
      st_nxt.flag_out    = lr_flag;
      st_nxt.rd_beat_out = st_r.rd_beat;
      st_nxt.rd_beat     = st_r.rd_beat + BEAT_W'(1);
    end
    else
    begin
      st_nxt.flag_out = {LANES{1'b1}};
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // State register; bursts restart at beat zero after reset
  always_ff @(posedge clk_sys_i)
  begin
    if (rst_i)
    begin
      st_r         <= '0;
      st_r.awready <= 1'b1;
      st_r.wready  <= 1'b1;
      st_r.arready <= 1'b1;
      st_r.term_en <= TERM_RST;
      st_r.mode5   <= MODE5_RST;
      st_r.flag_out <= {LANES{1'b1}};
    end
    else
    begin
      st_r <= st_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs straight from the state register
  assign s_axi_awready_o   = st_r.awready;
  assign s_axi_wready_o    = st_r.wready;
  assign s_axi_bvalid_o    = st_r.bvalid;
  assign s_axi_bresp_o     = st_r.bresp;
  assign s_axi_arready_o   = st_r.arready;
  assign s_axi_rvalid_o    = st_r.rvalid;
  assign s_axi_rdata_o     = st_r.rdata;
  assign s_axi_rresp_o     = st_r.rresp;
  assign arr_we_o          = st_r.arr_we;
  assign arr_data_o        = st_r.arr_data;
  assign arr_keep_o        = st_r.arr_keep;
  assign arr_beat_o        = st_r.arr_beat;
  assign dq_o              = st_r.dq_out;
  assign dq_oe_o           = st_r.dq_oe;
  assign bus_inv_flag_o    = st_r.flag_out;
  assign bus_inv_flag_oe_o = st_r.flag_oe;
  assign rd_beat_o         = st_r.rd_beat_out;
  assign rx_en_o           = st_r.rx_en;
  assign term_rtt_o        = st_r.term_rtt;

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (rst_i);

  property p_narrow_none;
    !HAS_MI |-> (!rx_en_o && bus_inv_flag_oe_o == '0);
  endproperty
  a_narrow_none: assert property (p_narrow_none) else $error("x4 part uses pin");

  property p_term_org;
    (term_rtt_o != 3'h0) |-> HAS_TD;
  endproperty
  a_term_org: assert property (p_term_org) else $error("strobe on wrong part");

  property p_term_quiet;
    eff_term |=> (bus_inv_flag_oe_o == '0 && !rx_en_o);
  endproperty
  a_term_quiet: assert property (p_term_quiet) else $error("pin active in strobe mode");

  property p_rx_off;
    (!st_r.rx_en && wr_valid_i) |=> (arr_keep_o == '1 && arr_data_o == $past(dq_i));
  endproperty
  a_rx_off: assert property (p_rx_off) else $error("pin acted with receiver off");

  property p_rd_off;
    (rd_valid_i && !eff_rd_inv) |=> (bus_inv_flag_oe_o == '0 && dq_o == $past(rd_data_i));
  endproperty
  a_rd_off: assert property (p_rd_off) else $error("read flag driven while off");

  property p_mask_drop;
    // Receiver lags the mode by a cycle; until it is on the pin reads high
    (eff_mask && st_r.rx_en && wr_valid_i) |=> (arr_keep_o[0] == $past(bus_inv_flag_i[0]));
  endproperty
  a_mask_drop: assert property (p_mask_drop) else $error("mask keep mismatch");

  property p_wr_inv;
    (eff_wr_inv && st_r.rx_en && wr_valid_i && !bus_inv_flag_i[0])
      |=> (arr_data_o[LANE_W-1:0] == ~$past(dq_i[LANE_W-1:0]));
  endproperty
  a_wr_inv: assert property (p_wr_inv) else $error("write byte not inverted");

  property p_rd_inv;
    (rd_valid_i && eff_rd_inv && dmb_zeros(8'(rd_data_i[LANE_W-1:0])) > ZERO_LIMIT)
      |=> (!bus_inv_flag_o[0] && bus_inv_flag_oe_o[0]);
  endproperty
  a_rd_inv: assert property (p_rd_inv) else $error("heavy read byte not flagged");

  property p_term_rtt;
    eff_term |=> (term_rtt_o == $past(dqs_rtt_i));
  endproperty
  a_term_rtt: assert property (p_term_rtt) else $error("strobe termination mismatch");

  // Beats may come with gaps, so the wrap is checked at the last beat itself
  sequence s_last_wr;
    (st_r.wr_beat == BEAT_W'(BURST_LEN - 1)) && wr_valid_i;
  endsequence

  property p_burst_wrap;
    s_last_wr |=> (arr_beat_o == BEAT_W'(BURST_LEN - 1) && st_r.wr_beat == '0);
  endproperty
  a_burst_wrap: assert property (p_burst_wrap) else $error("write burst not eight beats");

endmodule

// *** sim/dmb_ctrl_model.sv ***
`timescale 1ns/1ps
// Controller side of one byte lane: encodes write beats, restores read beats
module dmb_ctrl_model
(
  input  wire logic       clk_sys_i,
  input  wire logic       send_i,
  input  wire logic [7:0] byte_i,
  input  wire logic       drop_i,
  input  wire logic       wr_inv_en_i,
  input  wire logic       rd_inv_en_i,
  input  wire logic [7:0] pin_dq_i,
  input  wire logic       pin_flag_i,
  output logic            wr_valid_o,
  output logic      [7:0] dq_o,
  output logic            flag_o,
  output logic      [7:0] rd_byte_o
);
  logic       heavy;
  logic [7:0] enc;
  logic [7:0] last_r = 8'h5A;

  // Bytes with more than four zeros go out inverted and flagged low
  assign heavy = wr_inv_en_i && ($countones(~byte_i) > 4);
  assign enc = heavy ? ~byte_i : byte_i;
  assign wr_valid_o = send_i;
  // Between beats the lane toggles, so a stale byte can never pass for data
  assign dq_o = send_i ? enc : ~last_r;
  // Idle pin rests high; masking is never asked for while inverting
  assign flag_o = send_i ? !(heavy || (drop_i && !wr_inv_en_i)) : 1'b1;

  // Remember the last byte sent for the idle pattern
  always_ff @(posedge clk_sys_i)
  begin
    if (send_i)
    begin
      last_r <= enc;
    end
  end

  // Read bytes flagged low are restored before use
  assign rd_byte_o = (rd_inv_en_i && !pin_flag_i) ? ~pin_dq_i : pin_dq_i;
endmodule

// *** sim/dmb_sideband_bench.sv ***
`timescale 1ns/1ps
// Self-checking bench: register access plus write and read beats on one lane
module dmb_sideband_bench
  import dmb_pkg::*;
;
  logic        clk_sys_i, rst_i, s_axi_awvalid_i, s_axi_wvalid_i, s_axi_bready_i;
  logic        s_axi_arvalid_i, s_axi_rready_i, wr_valid_i, rd_valid_i;
  logic        s_axi_awready_o, s_axi_wready_o, s_axi_bvalid_o, s_axi_arready_o;
  logic        s_axi_rvalid_o, arr_we_o, dq_oe_o, rx_en_o;
  logic [7:0]  s_axi_awaddr_i, s_axi_araddr_i, dq_i, rd_data_i, arr_data_o, dq_o;
  logic [31:0] s_axi_wdata_i, s_axi_rdata_o;
  logic [3:0]  s_axi_wstrb_i;
  logic [1:0]  s_axi_bresp_o, s_axi_rresp_o;
  logic [0:0]  bus_inv_flag_i, bus_inv_flag_o, bus_inv_flag_oe_o, arr_keep_o;
  logic [2:0]  dqs_rtt_i, term_rtt_o, arr_beat_o, rd_beat_o;
  logic        send, drop, wr_inv_en, rd_inv_en, ctl_flag;
  logic [7:0]  send_byte, ctl_dq, rd_byte;
  int          err_count, comparisons, beat_cnt;
  logic [7:0]  pat [8] = '{8'h01, 8'h0F, 8'h07, 8'hFF, 8'h00, 8'h80, 8'hE0, 8'h3F};

  initial clk_sys_i = 1'b0;
  always #10 clk_sys_i = ~clk_sys_i;

  // Shared pins resolve from whichever side is driving them
  assign bus_inv_flag_i = bus_inv_flag_oe_o[0] ? bus_inv_flag_o : ctl_flag;
  assign dq_i = dq_oe_o ? dq_o : ctl_dq;

  dmb_sideband #(.DQ_W(8)) i_dut (.clk_sys_i, .rst_i, .s_axi_awvalid_i, .s_axi_awready_o,
    .s_axi_awaddr_i, .s_axi_wvalid_i, .s_axi_wready_o, .s_axi_wdata_i, .s_axi_wstrb_i,
    .s_axi_bvalid_o, .s_axi_bready_i, .s_axi_bresp_o, .s_axi_arvalid_i, .s_axi_arready_o,
    .s_axi_araddr_i, .s_axi_rvalid_o, .s_axi_rready_i, .s_axi_rdata_o, .s_axi_rresp_o,
    .wr_valid_i, .dq_i, .bus_inv_flag_i, .rd_valid_i, .rd_data_i, .dqs_rtt_i, .arr_we_o,
    .arr_data_o, .arr_keep_o, .arr_beat_o, .dq_o, .dq_oe_o, .bus_inv_flag_o,
    .bus_inv_flag_oe_o, .rd_beat_o(), .rx_en_o, .term_rtt_o);

  dmb_ctrl_model i_ctl (.clk_sys_i, .send_i(send), .byte_i(send_byte), .drop_i(drop),
    .wr_inv_en_i(wr_inv_en), .rd_inv_en_i(rd_inv_en), .pin_dq_i(dq_i),
    .pin_flag_i(bus_inv_flag_i[0]), .wr_valid_o(wr_valid_i), .dq_o(ctl_dq),
    .flag_o(ctl_flag), .rd_byte_o(rd_byte));

  ////////////////////////////////////////////////////////////////
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      err_count++;
      $display("unexpected %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic final_report();
    if (err_count == 0 && comparisons > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  // Ready is sampled before each edge; a channel is released right after its edge
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    logic       aw_hit, w_hit, b_hit;
    logic [1:0] resp;
    s_axi_awaddr_i <= a;
    s_axi_wdata_i <= d;
    s_axi_awvalid_i <= 1'b1;
    s_axi_wvalid_i <= 1'b1;
    s_axi_bready_i <= 1'b1;
    b_hit = 1'b0;
    while (!b_hit)
    begin
      @(negedge clk_sys_i);
      aw_hit = s_axi_awvalid_i && s_axi_awready_o;
      w_hit = s_axi_wvalid_i && s_axi_wready_o;
      b_hit = s_axi_bvalid_o && s_axi_bready_i;
      resp = s_axi_bresp_o;
      @(posedge clk_sys_i);
      if (aw_hit) s_axi_awvalid_i <= 1'b0;
      if (w_hit) s_axi_wvalid_i <= 1'b0;
    end
    s_axi_bready_i <= 1'b0;
    chk("bresp", 32'(resp), 32'(er));
    @(posedge clk_sys_i);
  endtask

  task automatic axi_rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
    logic        ar_hit, r_hit;
    logic [31:0] data;
    logic [1:0]  resp;
    s_axi_araddr_i <= a;
    s_axi_arvalid_i <= 1'b1;
    s_axi_rready_i <= 1'b1;
    r_hit = 1'b0;
    while (!r_hit)
    begin
      @(negedge clk_sys_i);
      ar_hit = s_axi_arvalid_i && s_axi_arready_o;
      r_hit = s_axi_rvalid_o && s_axi_rready_i;
      data = s_axi_rdata_o;
      resp = s_axi_rresp_o;
      @(posedge clk_sys_i);
      if (ar_hit) s_axi_arvalid_i <= 1'b0;
    end
    s_axi_rready_i <= 1'b0;
    chk("rdata", data, ed);
    chk("rresp", 32'(resp), 32'(er));
    @(posedge clk_sys_i);
  endtask

  // One write beat through the controller; the array port answers a cycle later
  task automatic wbeat(input logic [7:0] b, input logic dr, input logic [7:0] ed,
                       input logic ek);
    send <= 1'b1;
    send_byte <= b;
    drop <= dr;
    @(posedge clk_sys_i);
    send <= 1'b0;
    #1;
    chk("arr_we", 32'(arr_we_o), 32'h1);
    chk("arr_keep", 32'(arr_keep_o), 32'(ek));
    if (ek) chk("arr_data", 32'(arr_data_o), 32'(ed));
    chk("arr_beat", 32'(arr_beat_o), 32'(beat_cnt % 8));
    beat_cnt++;
    @(posedge clk_sys_i);
  endtask

  // One read beat from the array; expected lane byte and flag worked out here
  task automatic rbeat(input logic [7:0] b, input logic inv);
    logic       heavy;
    logic [7:0] exp_dq;
    heavy = inv && ($countones(~b) > 4);
    exp_dq = heavy ? ~b : b;
    rd_valid_i <= 1'b1;
    rd_data_i <= b;
    @(posedge clk_sys_i);
    rd_valid_i <= 1'b0;
    #1;
    chk("dq_out", 32'(dq_o), 32'(exp_dq));
    chk("dq_oe", 32'(dq_oe_o), 32'h1);
    chk("flag_oe", 32'(bus_inv_flag_oe_o), 32'(inv));
    if (inv) chk("flag", 32'(bus_inv_flag_o), 32'(!heavy));
    chk("decoded", 32'(rd_byte), 32'(b));
    @(posedge clk_sys_i);
  endtask

  ////////////////////////////////////////////////////////////////
  // Watchdog: the sequence needs well under a thousand cycles
  initial
  begin
    repeat (5000) @(posedge clk_sys_i);
    err_count++;
    final_report();
  end

  initial
  begin
    {s_axi_awvalid_i, s_axi_wvalid_i, s_axi_bready_i, s_axi_arvalid_i, s_axi_rready_i} = '0;
    {rd_valid_i, send, drop, wr_inv_en, rd_inv_en} = '0;
    {s_axi_awaddr_i, s_axi_araddr_i, s_axi_wdata_i, send_byte, rd_data_i} = '0;
    rst_i = 1'b1;
    s_axi_wstrb_i = 4'hF;
    dqs_rtt_i = 3'h5;
    err_count = 0;
    comparisons = 0;
    beat_cnt = 0;
    repeat (3) @(posedge clk_sys_i);
    rst_i <= 1'b0;
    #1;
    chk("flag_idle", 32'(bus_inv_flag_o), 32'h1);
    chk("rx_en", 32'(rx_en_o), 32'h0);
    @(posedge clk_sys_i);
    axi_rd(MODE1_ADDR, 32'h0, RESP_OKAY);
    axi_rd(MODE5_ADDR, 32'h0, RESP_OKAY);
    axi_rd(STATUS_ADDR, 32'h0000_00C0, RESP_OKAY);
    wbeat(8'h01, 1'b1, 8'h01, 1'b1);
    rbeat(8'h01, 1'b0);
    axi_wr(MODE5_ADDR, 32'h0000_0400, RESP_OKAY);
    axi_rd(STATUS_ADDR, 32'h0000_00D1, RESP_OKAY);
    wbeat(8'hA5, 1'b1, 8'hA5, 1'b0);
    wbeat(8'h3C, 1'b0, 8'h3C, 1'b1);
    axi_wr(MODE5_ADDR, 32'h0000_0800, RESP_OKAY);
    wr_inv_en <= 1'b1;
    axi_rd(STATUS_ADDR, 32'h0000_00D2, RESP_OKAY);
    foreach (pat[i]) wbeat(pat[i], 1'b0, pat[i], 1'b1);
    wr_inv_en <= 1'b0;
    axi_wr(MODE5_ADDR, 32'h0000_1000, RESP_OKAY);
    rd_inv_en <= 1'b1;
    axi_rd(STATUS_ADDR, 32'h0000_00C4, RESP_OKAY);
    foreach (pat[i]) rbeat(pat[i], 1'b1);
    rd_inv_en <= 1'b0;
    axi_wr(MODE5_ADDR, 32'h0000_0C00, RESP_OKAY);
    axi_rd(STATUS_ADDR, 32'h0000_00F1, RESP_OKAY);
    wbeat(8'h5A, 1'b1, 8'h5A, 1'b0);
    chk("term_off", 32'(term_rtt_o), 32'h0);
    axi_wr(MODE1_ADDR, 32'h0000_0800, RESP_OKAY);
    axi_wr(MODE5_ADDR, 32'h0000_1400, RESP_OKAY);
    axi_rd(STATUS_ADDR, 32'h0000_00C8, RESP_OKAY);
    chk("term_on", 32'(term_rtt_o), 32'h5);
    chk("rx_strobe", 32'(rx_en_o), 32'h0);
    wbeat(8'h01, 1'b1, 8'h01, 1'b1);
    rbeat(8'h01, 1'b0);
    axi_wr(8'h10, 32'hFFFF_FFFF, RESP_DECERR);
    axi_rd(8'h10, 32'h0, RESP_DECERR);
    axi_wr(STATUS_ADDR, 32'hFFFF_FFFF, RESP_OKAY);
    axi_rd(STATUS_ADDR, 32'h0000_00C8, RESP_OKAY);
    axi_rd(COUNT_ADDR, 32'h0000_0002, RESP_OKAY);
    final_report();
  end
endmodule
